// [common/rsq_defines.svh]
// constants of the reset sequencer: offsets, fields, reset values, timing
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RSQ_ADR_STATUS 8'h00
`define RSQ_ADR_KEY 8'h04
`define RSQ_ADR_RSTFLAG 8'h08
`define RSQ_ADR_IRQ_STATUS 8'h0c
`define RSQ_ADR_IRQ_MASK 8'h10

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define RSQ_STATUS_TO 0
`define RSQ_STATUS_PDF 1
`define RSQ_STATUS_RUN 2
`define RSQ_STATUS_ARMED 3
`define RSQ_KEY_W 5
`define RSQ_IRQ_W 3
`define RSQ_IRQ_WDT_RESET 0
`define RSQ_IRQ_WDT_WAKE 1
`define RSQ_IRQ_KEY_RESET 2
`define RSQ_PORT_W 4

// ----------------------------------------------------------------------
// reset values and key codes
// ----------------------------------------------------------------------
`define RSQ_KEY_ENABLE 5'h0a
`define RSQ_KEY_DISABLE 5'h15
`define RSQ_KEY_RESET_VAL 5'h0a
`define RSQ_PORT_PRESET 4'hf

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RSQ_CLK_PERIOD_NS 10
`define RSQ_POR_DELAY_NS 50000000
`define RSQ_WDT_DELAY_NS 16700000
`define RSQ_SOFT_DELAY_NS 1000
`define RSQ_CNT_W 23

`endif

// [common/rsq_pkg.sv]
// types used by the reset sequencer module rsq_sequencer
`include "rsq_defines.svh"
package rsq_pkg;

   // sequencer phases
   typedef enum logic [1:0] {
      ST_POR_HOLD,
      ST_WDT_HOLD,
      ST_RUN
   } rsq_state_t;

   // whole state of the sequencer core
   typedef struct packed {
      rsq_state_t state;
      logic timeoutFlag;
      logic powerdownFlag;
      logic configResetFlag;
      logic [`RSQ_KEY_W-1:0] watchdogEnableKey;
      logic softArmed;
      logic [`RSQ_IRQ_W-1:0] irqStatus;
      logic [`RSQ_IRQ_W-1:0] irqMask;
      logic irq;
      logic ack;
      logic [31:0] datOut;
      logic coreResetn;
      logic pcSpClear;
      logic wdtClear;
      logic [`RSQ_PORT_W-1:0] portPreset;
   } rsq_state_s_t;

endpackage

// [core/rsq_reset_sync.sv]
// two-flop release synchroniser for the asynchronous reset
`timescale 1ns/1ns
module rsq_reset_sync (
   // clock and raw reset
   input wire logic clk,
   input wire logic resetn,
   // synchronised reset
   output logic resetnSync
);

   typedef struct packed {
      logic stage1;
      logic stage2;
   } rsq_sync_t;

   rsq_sync_t s;
   rsq_sync_t next_s;

   // assert at once, release two edges later to avoid a metastable release
   always_comb begin
      next_s.stage1 = 1'b1;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign resetnSync = s.stage2;

endmodule // rsq_reset_sync

// [core/rsq_delay_counter.sv]
// loadable down-counter that pulses done when its delay has run out
`timescale 1ns/1ns
module rsq_delay_counter #(
   parameter int W = 23,
   parameter logic [W-1:0] RESET_COUNT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic load,
   input wire logic [W-1:0] loadValue,
   // status
   output logic done
);

   typedef struct packed {
      logic [W-1:0] count;
      logic running;
   } rsq_cnt_t;

   rsq_cnt_t s;
   rsq_cnt_t next_s;

   // a load restarts the count, done fires loadValue+1 cycles later
   always_comb begin
      next_s = s;
      if (load) begin
         next_s.count = loadValue;
         next_s.running = 1'b1;
      end else if (s.running) begin
         if (s.count == '0) begin
            next_s.running = 1'b0;
         end else begin
            next_s.count = s.count - 1'b1;
         end
      end
   end

   // counting starts straight out of reset for the power-on delay
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s.count <= RESET_COUNT;
         s.running <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // done ignores load: the sequencer derives load from done, a loop otherwise
   assign done = s.running && (s.count == '0);

endmodule // rsq_delay_counter

// [core/rsq_sequencer.sv]
// reset sequencer: start-up delays, reset-cause flags and core reset control
`timescale 1ns/1ns
`include "rsq_defines.svh"
module rsq_sequencer #(
   parameter int CNT_W = `RSQ_CNT_W,
   parameter int POR_DELAY_CYC =
      (`RSQ_POR_DELAY_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS,
   parameter int WDT_DELAY_CYC =
      (`RSQ_WDT_DELAY_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS,
   parameter int SOFT_DELAY_CYC =
      (`RSQ_SOFT_DELAY_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic resetn,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // events from watchdog and core
   input wire logic wdtTimeout,
   input wire logic sleepMode,
   input wire logic haltExec,
   input wire logic clrWdtExec,
   // reset controls to core and peripherals
   output logic coreResetn,
   output logic pcSpClear,
   output logic wdtClear,
   output logic [`RSQ_PORT_W-1:0] portPreset,
   // reset-cause flags and key
   output logic timeoutFlag,
   output logic powerdownFlag,
   output logic configResetFlag,
   output logic [`RSQ_KEY_W-1:0] watchdogEnableKey,
   // interrupt
   output logic irq
);

   // ---------------------------------------------------------------
   // reset release and delay counter
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] WDT_LOAD = CNT_W'(WDT_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] SOFT_LOAD = CNT_W'(SOFT_DELAY_CYC - 1);

   logic rstnSync;
   logic cntLoad;
   logic [CNT_W-1:0] cntValue;
   logic cntDone;
   rsq_pkg::rsq_state_s_t s;
   rsq_pkg::rsq_state_s_t next_s;

   rsq_reset_sync u_reset_sync (
      .clk(clk),
      .resetn(resetn),
      .resetnSync(rstnSync)
   );

   // power-on delay starts counting the moment the reset releases
   rsq_delay_counter #(
      .W(CNT_W),
      .RESET_COUNT(POR_LOAD)
   ) u_delay (
      .clk(clk),
      .resetn(rstnSync),
      .load(cntLoad),
      .loadValue(cntValue),
      .done(cntDone)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic busReq;
   logic busWrite;
   logic lowLane;
   logic keyBad;
   logic inRun;

   // write lands at the edge where ack is seen high by the master
   assign busReq = wb_cyc_i && wb_stb_i;
   assign busWrite = busReq && wb_we_i && s.ack;
   assign lowLane = wb_sel_i[0];
   assign inRun = (s.state == rsq_pkg::ST_RUN);
   assign keyBad = (s.watchdogEnableKey != `RSQ_KEY_ENABLE) &&
      (s.watchdogEnableKey != `RSQ_KEY_DISABLE);

   // read mux, unmapped addresses read zero
   function automatic logic [31:0] readWord(input rsq_pkg::rsq_state_s_t st,
                                            input logic [7:0] adr);
      logic [31:0] w;
      w = '0;
      unique case (adr)
         `RSQ_ADR_STATUS: begin
            w[`RSQ_STATUS_TO] = st.timeoutFlag;
            w[`RSQ_STATUS_PDF] = st.powerdownFlag;
            w[`RSQ_STATUS_RUN] = st.coreResetn;
            w[`RSQ_STATUS_ARMED] = st.softArmed;
         end
         `RSQ_ADR_KEY: w[`RSQ_KEY_W-1:0] = st.watchdogEnableKey;
         `RSQ_ADR_RSTFLAG: w[0] = st.configResetFlag;
         `RSQ_ADR_IRQ_STATUS: w[`RSQ_IRQ_W-1:0] = st.irqStatus;
         `RSQ_ADR_IRQ_MASK: w[`RSQ_IRQ_W-1:0] = st.irqMask;
         default: w = '0;
      endcase
      return w;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // bus effects first, hardware events after so a set beats a clear
   always_comb begin
      next_s = s;
      cntLoad = 1'b0;
      cntValue = WDT_LOAD;
      next_s.pcSpClear = 1'b0;

      // one-cycle ack, dropped the cycle after it was given
      next_s.ack = busReq && !s.ack;
      if (busReq && !s.ack) begin
         next_s.datOut = readWord(s, wb_adr_i);
      end

      if (busWrite && lowLane) begin
         unique case (wb_adr_i)
            `RSQ_ADR_KEY:
               next_s.watchdogEnableKey = wb_dat_i[`RSQ_KEY_W-1:0];
            `RSQ_ADR_RSTFLAG:
               if (!wb_dat_i[0]) begin
                  next_s.configResetFlag = 1'b0;
               end
            `RSQ_ADR_IRQ_STATUS:
               next_s.irqStatus = s.irqStatus & ~wb_dat_i[`RSQ_IRQ_W-1:0];
            `RSQ_ADR_IRQ_MASK:
               next_s.irqMask = wb_dat_i[`RSQ_IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      unique case (s.state)
         rsq_pkg::ST_POR_HOLD: begin
            // core, timer and ports held in their preset state
            next_s.coreResetn = 1'b0;
            next_s.wdtClear = 1'b1;
            next_s.portPreset = `RSQ_PORT_PRESET;
            if (cntDone) begin
               next_s.state = rsq_pkg::ST_RUN;
               next_s.coreResetn = 1'b1;
               next_s.wdtClear = 1'b0;
            end
         end
         rsq_pkg::ST_WDT_HOLD: begin
            // a further time-out here is ignored, the reset is already in force
            if (cntDone) begin
               next_s.state = rsq_pkg::ST_RUN;
               next_s.coreResetn = 1'b1;
               next_s.wdtClear = 1'b0;
            end
         end
         rsq_pkg::ST_RUN: begin
            // powerdown flag follows halt and clear-watchdog, halt wins a tie
            if (clrWdtExec) begin
               next_s.powerdownFlag = 1'b0;
            end
            if (haltExec) begin
               next_s.powerdownFlag = 1'b1;
            end

            if (wdtTimeout && sleepMode) begin
               // wake-up reset touches only program counter and stack pointer
               next_s.pcSpClear = 1'b1;
               next_s.timeoutFlag = 1'b1;
               next_s.powerdownFlag = 1'b1;
               next_s.irqStatus[`RSQ_IRQ_WDT_WAKE] = 1'b1;
            end else if (wdtTimeout) begin
               // full reset; powerdown flag is left as it was before
               next_s.state = rsq_pkg::ST_WDT_HOLD;
               next_s.timeoutFlag = 1'b1;
               next_s.powerdownFlag = s.powerdownFlag;
               next_s.coreResetn = 1'b0;
               next_s.wdtClear = 1'b1;
               next_s.portPreset = `RSQ_PORT_PRESET;
               next_s.watchdogEnableKey = `RSQ_KEY_RESET_VAL;
               next_s.softArmed = 1'b0;
               next_s.irqStatus[`RSQ_IRQ_WDT_RESET] = 1'b1;
               cntLoad = 1'b1;
               cntValue = WDT_LOAD;
            end else if (s.softArmed && cntDone) begin
               // bad key delay expired: reset once, even if the key was mended
               next_s.state = rsq_pkg::ST_WDT_HOLD;
               next_s.configResetFlag = 1'b1;
               next_s.coreResetn = 1'b0;
               next_s.wdtClear = 1'b1;
               next_s.portPreset = `RSQ_PORT_PRESET;
               next_s.watchdogEnableKey = `RSQ_KEY_RESET_VAL;
               next_s.softArmed = 1'b0;
               next_s.irqStatus[`RSQ_IRQ_KEY_RESET] = 1'b1;
               cntLoad = 1'b1;
               cntValue = WDT_LOAD;
            end else if (keyBad && !s.softArmed) begin
               next_s.softArmed = 1'b1;
               cntLoad = 1'b1;
               cntValue = SOFT_LOAD;
            end
         end
         default: begin
            // unused state code: hold the core and rerun the power-on delay
            next_s.state = rsq_pkg::ST_POR_HOLD;
            next_s.coreResetn = 1'b0;
            next_s.wdtClear = 1'b1;
            cntLoad = 1'b1;
            cntValue = POR_LOAD;
         end
      endcase

      next_s.irq = |(next_s.irqStatus & next_s.irqMask);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // power-on values: flags clear, core held, ports preset high
   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         s.state <= rsq_pkg::ST_POR_HOLD;
         s.timeoutFlag <= 1'b0;
         s.powerdownFlag <= 1'b0;
         s.configResetFlag <= 1'b0;
         s.watchdogEnableKey <= `RSQ_KEY_RESET_VAL;
         s.softArmed <= 1'b0;
         s.irqStatus <= '0;
         s.irqMask <= '0;
         s.irq <= 1'b0;
         s.ack <= 1'b0;
         s.datOut <= '0;
         s.coreResetn <= 1'b0;
         s.pcSpClear <= 1'b0;
         s.wdtClear <= 1'b1;
         s.portPreset <= `RSQ_PORT_PRESET;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.datOut;
   assign coreResetn = s.coreResetn;
   assign pcSpClear = s.pcSpClear;
   assign wdtClear = s.wdtClear;
   assign portPreset = s.portPreset;
   assign timeoutFlag = s.timeoutFlag;
   assign powerdownFlag = s.powerdownFlag;
   assign configResetFlag = s.configResetFlag;
   assign watchdogEnableKey = s.watchdogEnableKey;
   assign irq = s.irq;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_port_preset: assert property (@(posedge clk) disable iff (!rstnSync)
      !coreResetn |-> portPreset == 4'hf && wdtClear)
      else $error("ports not preset high while core held");

   a_hold_release: assert property (@(posedge clk) disable iff (!rstnSync)
      $rose(coreResetn) |-> $past(cntDone) && $past(s.state) != rsq_pkg::ST_RUN)
      else $error("core released without expired delay");

   a_wdt_normal: assert property (@(posedge clk) disable iff (!rstnSync)
      inRun && wdtTimeout && !sleepMode
      |=> timeoutFlag && !coreResetn && powerdownFlag == $past(powerdownFlag))
      else $error("normal watchdog reset wrong");

   a_sleep_wake: assert property (@(posedge clk) disable iff (!rstnSync)
      inRun && wdtTimeout && sleepMode
      |=> pcSpClear && coreResetn && timeoutFlag && powerdownFlag ##1 !pcSpClear)
      else $error("sleep watchdog wake wrong");

   a_halt_pdf: assert property (@(posedge clk) disable iff (!rstnSync)
      inRun && haltExec && !wdtTimeout |=> powerdownFlag)
      else $error("halt did not set powerdown flag");

   a_clr_pdf: assert property (@(posedge clk) disable iff (!rstnSync)
      inRun && clrWdtExec && !haltExec && !wdtTimeout |=> !powerdownFlag)
      else $error("clear watchdog did not clear powerdown flag");

   a_por_flags: assert property (@(posedge clk)
      $rose(rstnSync) |-> !timeoutFlag && !powerdownFlag && !coreResetn)
      else $error("flags not clear after power-on");

   a_key_reset: assert property (@(posedge clk) disable iff (!rstnSync)
      $rose(configResetFlag) |-> $fell(coreResetn) &&
      watchdogEnableKey == 5'h0a)
      else $error("bad key reset wrong");

   a_wb_ack: assert property (@(posedge clk) disable iff (!rstnSync)
      busReq && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not one cycle");

endmodule // rsq_sequencer

// [verif/rsq_core_model.sv]
// stand-in for the watchdog counter and processor core around the sequencer
`timescale 1ns/1ns
module rsq_core_model #(
   parameter int PERIOD = 30
) (
   // clock and controls from the sequencer
   input wire logic clk,
   input wire logic coreResetn,
   input wire logic wdtClear,
   input wire logic pcSpClear,
   // commands from the bench
   input wire logic wdtRun,
   input wire logic haltReq,
   input wire logic clrReq,
   // events to the sequencer
   output logic wdtTimeout,
   output logic sleepMode,
   output logic haltExec,
   output logic clrWdtExec
);
   int cnt;

   // ----------------------------------------------------------------
   // watchdog count and sleep state
   // ----------------------------------------------------------------
   initial begin
      cnt = 0;
      wdtTimeout = 1'b0;
      sleepMode = 1'b0;
      haltExec = 1'b0;
      clrWdtExec = 1'b0;
   end

   // a held core keeps the count at zero; halt and clear restart it
   always @(posedge clk) begin
      haltExec <= 1'b0;
      clrWdtExec <= 1'b0;
      wdtTimeout <= 1'b0;
      if (!coreResetn || wdtClear) begin
         cnt <= 0;
         sleepMode <= 1'b0;
      end else begin
         if (pcSpClear) sleepMode <= 1'b0; // wake-up ends sleep
         if (haltReq) begin
            haltExec <= 1'b1;
            sleepMode <= 1'b1;
            cnt <= 0;
         end else if (clrReq) begin
            clrWdtExec <= 1'b1;
            cnt <= 0;
         end else if (wdtRun && cnt == PERIOD - 1) begin
            wdtTimeout <= 1'b1; // one-cycle overflow pulse
            cnt <= 0;
         end else if (wdtRun) begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule // rsq_core_model

// [verif/test_mcu_reset_sequencer.sv]
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
`include "rsq_defines.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module test_mcu_reset_sequencer;
   localparam int POR = 20, WDT = 10, SOFT = 5;
   logic clk, resetn, cyc, stb, we, ack, wdtRun, haltReq, clrReq;
   logic wdtTimeout, sleepMode, haltExec, clrWdtExec, irq;
   logic coreResetn, pcSpClear, wdtClear, timeoutFlag, powerdownFlag, configResetFlag;
   logic [7:0] adr;
   logic [3:0] sel, portPreset;
   logic [4:0] watchdogEnableKey, k;
   logic [31:0] datI, datO, q;
   int fail_count, checks, n;
   longint t0;

   rsq_sequencer #(.POR_DELAY_CYC(POR), .WDT_DELAY_CYC(WDT), .SOFT_DELAY_CYC(SOFT))
   u_rsq_sequencer (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
      .wb_ack_o(ack), .wdtTimeout(wdtTimeout), .sleepMode(sleepMode),
      .haltExec(haltExec), .clrWdtExec(clrWdtExec), .coreResetn(coreResetn),
      .pcSpClear(pcSpClear), .wdtClear(wdtClear), .portPreset(portPreset),
      .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag),
      .configResetFlag(configResetFlag), .watchdogEnableKey(watchdogEnableKey), .irq(irq));

   rsq_core_model #(.PERIOD(30)) u_rsq_core_model (.clk(clk), .coreResetn(coreResetn),
      .wdtClear(wdtClear), .pcSpClear(pcSpClear), .wdtRun(wdtRun), .haltReq(haltReq),
      .clrReq(clrReq), .wdtTimeout(wdtTimeout), .sleepMode(sleepMode),
      .haltExec(haltExec), .clrWdtExec(clrWdtExec));

   // ----------------------------------------------------------------
   // clock, hang guard, helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // release must land on a rising clock edge
   always @(posedge coreResetn) `CHK("releaseEdge", 1'b1, clk)

   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      $display("[ERR] run expected end seen timeout");
      give_verdict();
   end

   task give_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one classic cycle; held until ack is seen at a rising edge
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int c;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      c = 0;
      // ack and read data are read before this edge's own updates land
      do begin
         @(posedge clk);
         c++;
      end while (ack !== 1'b1 && c < 20);
      if (ack !== 1'b1) begin
         fail_count++;
         $display("[ERR] ack expected 1 seen timeout");
         give_verdict();
      end
      q = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
      wb(a, 1'b0, 32'h0);
      `CHK(nm, ex, q)
   endtask

   // which: 0 core reset, 1 wake pulse; waits at falling edges
   task wait_for(input int which, input logic val, input int lim);
      n = 0;
      while (((which == 0) ? coreResetn : pcSpClear) !== val && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         $display("[ERR] wait %0d expected %0h seen timeout", which, val);
         give_verdict();
      end
   endtask

   // event request; flags settle one edge after the model's pulse
   task req(input logic halt);
      @(posedge clk);
      haltReq <= halt;
      clrReq <= ~halt;
      @(posedge clk);
      haltReq <= 1'b0;
      clrReq <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask

   task watchdog_reset;
      @(posedge clk) wdtRun <= 1'b1;
      wait_for(0, 1'b0, 60);
      t0 = $time; // hold is timed from the fall just seen
      @(posedge clk) wdtRun <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {resetn, cyc, stb, we, wdtRun, haltReq, clrReq} = '0;
      adr = 8'h00;
      sel = 4'hf;
      datI = 32'h0;
      fail_count = 0;
      checks = 0;
      void'($urandom(92696));
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK("coreResetn", 1'b0, coreResetn)
      `CHK("portPreset", 4'hf, portPreset)
      `CHK("wdtClear", 1'b1, wdtClear)
      `CHK("flags", 2'b00, {timeoutFlag, powerdownFlag})
      @(posedge clk) resetn <= 1'b1;
      t0 = $time;
      rchk("key", `RSQ_ADR_KEY, 32'h0a);
      rchk("mask", `RSQ_ADR_IRQ_MASK, 32'h0);
      rchk("unmapped", 8'h40, 32'h0);
      wait_for(0, 1'b1, POR + 40);
      n = int'(($time - t0) / 10);
      `CHK("porDelay", 1'b1, n >= POR && n <= POR + 6)
      rchk("status", `RSQ_ADR_STATUS, 32'h4);
      req(1'b1);
      `CHK("pdfHalt", 1'b1, powerdownFlag)
      req(1'b0);
      `CHK("pdfClr", 1'b0, powerdownFlag)
      // sleep wake-up must leave the disabled key alone
      wb(`RSQ_ADR_KEY, 1'b1, 32'h15);
      req(1'b1);
      @(posedge clk) wdtRun <= 1'b1;
      wait_for(1, 1'b1, 60);
      `CHK("flagsSleep", 2'b11, {timeoutFlag, powerdownFlag})
      `CHK("noHold", 1'b1, coreResetn)
      @(negedge clk);
      `CHK("wakePulse", 1'b0, pcSpClear)
      @(posedge clk) wdtRun <= 1'b0;
      rchk("keyKept", `RSQ_ADR_KEY, 32'h15);
      rchk("statusSleep", `RSQ_ADR_STATUS, 32'h7);
      // normal time-out with powerdown already set
      watchdog_reset();
      `CHK("flagsNorm", 2'b11, {timeoutFlag, powerdownFlag})
      `CHK("wdtHeld", 1'b1, wdtClear)
      `CHK("keyBack", 5'h0a, watchdogEnableKey)
      wait_for(0, 1'b1, WDT + 20);
      n = int'(($time - t0) / 10);
      `CHK("wdtDelay", 1'b1, n >= WDT && n <= WDT + 4)
      // interrupts: raise, mask, clear
      rchk("irqSt", `RSQ_ADR_IRQ_STATUS, 32'h3);
      `CHK("irqMasked", 1'b0, irq)
      for (int b = 1; b >= 0; b--) begin
         wb(`RSQ_ADR_IRQ_MASK, 1'b1, 32'h1 << b);
         repeat (2) @(negedge clk);
         `CHK("irqOn", 1'b1, irq)
         wb(`RSQ_ADR_IRQ_STATUS, 1'b1, 32'h1 << b);
         repeat (2) @(negedge clk);
         `CHK("irqOff", 1'b0, irq)
      end
      rchk("irqClr", `RSQ_ADR_IRQ_STATUS, 32'h0);
      // random bad keys, each followed by a soft reset
      for (int i = 0; i < 3; i++) begin
         do k = 5'($urandom); while (k == 5'h0a || k == 5'h15);
         repeat ($urandom % 4) @(posedge clk);
         wb(`RSQ_ADR_KEY, 1'b1, {27'($urandom), k});
         rchk("armed", `RSQ_ADR_STATUS, 32'hf);
         wait_for(0, 1'b0, SOFT + 20);
         `CHK("cfgFlag", 1'b1, configResetFlag)
         `CHK("keyRestore", 5'h0a, watchdogEnableKey)
         wait_for(0, 1'b1, WDT + 20);
         rchk("rstFlag", `RSQ_ADR_RSTFLAG, 32'h1);
         wb(`RSQ_ADR_RSTFLAG, 1'b1, 32'h0);
      end
      wb(`RSQ_ADR_KEY, 1'b1, 32'h15);
      wb(`RSQ_ADR_KEY, 1'b1, 32'h0a);
      repeat (SOFT + 8) @(negedge clk);
      `CHK("validKeys", 2'b10, {coreResetn, configResetFlag})
      // second power-on in mid-run
      wb(`RSQ_ADR_IRQ_MASK, 1'b1, 32'h7);
      @(negedge clk);
      `CHK("irqKey", 1'b1, irq)
      @(posedge clk) resetn <= 1'b0;
      @(negedge clk);
      `CHK("flagsPor", 2'b00, {timeoutFlag, powerdownFlag})
      `CHK("irqPor", 1'b0, irq)
      `CHK("coreHeld", 1'b0, coreResetn)
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rchk("maskPor", `RSQ_ADR_IRQ_MASK, 32'h0);
      wait_for(0, 1'b1, POR + 40);
      watchdog_reset();
      `CHK("flagsNorm2", 2'b10, {timeoutFlag, powerdownFlag})
      wait_for(0, 1'b1, WDT + 20);
      give_verdict();
   end
endmodule // test_mcu_reset_sequencer
